// >>> src/slcs_gap_if.sv
`timescale 1ns/1ps
interface slcs_gap_if;
    import slcs_pkg::*;
    slcs_gap_t sym_gap;
    slcs_gap_t tok_gap;
    logic sent;
    logic last;
    logic permit;
    modport ctl (output sym_gap, output tok_gap, output sent, output last, input permit);
    modport gap (input sym_gap, input tok_gap, input sent, input last, output permit);
endinterface

// >>> src/slcs_map.svh
`ifndef SLCS_MAP_SVH
`define SLCS_MAP_SVH
// =====================================================
// Register indices (byte address is four times index)
`define SLCS_NLINK 8
`define SLCS_IDX_SPARE 8'h11
`define SLCS_IDX_DEBUG 8'h1F
`define SLCS_IDX_LINK 8'h20
`define SLCS_IDX_PROCESSOR_LINK 8'h40
`define SLCS_IDX_SETUP 8'h80
`define SLCS_IDX_STATIC 8'hA0
`define SLCS_GRP_MASK 8'hF8
// =====================================================
// Field positions
`define SLCS_KIND_LO 24
`define SLCS_DEST_LO 16
`define SLCS_DIR_LO 8
`define SLCS_NET_LO 4
`define SLCS_JUNK_BIT 2
`define SLCS_DBUSY_BIT 1
`define SLCS_SBUSY_BIT 0
`define SLCS_EN_BIT 31
`define SLCS_FIVE_BIT 30
`define SLCS_ERR_BIT 27
`define SLCS_CISS_BIT 26
`define SLCS_CHELD_BIT 25
`define SLCS_CREDIT_TOKEN_A_BIT 24
`define SLCS_RXRST_BIT 23
`define SLCS_SGAP_LO 11
`define SLCS_TGAP_LO 0
`define SLCS_SEN_BIT 31
`define SLCS_PROC_BIT 8
`define SLCS_CHAN_LO 0
`define SLCS_DBG_RSV_BIT 4
`define SLCS_STATIC_SWAP 3'h2
// =====================================================
// Reset values and responses
`define SLCS_RST_WORD 32'h0000_0000
`define SLCS_RESP_OKAY 2'h0
`define SLCS_RESP_SLVERR 2'h2
`endif

// >>> src/slcs_pkg.sv
package slcs_pkg;
    // =====================================================
    // Types
    typedef logic [10:0] slcs_gap_t;
    typedef enum logic [1:0] {
        switch_link,
        processor_link,
        switch_control_target,
        undefined_target
    } slcs_tgt_t;
    typedef enum logic [2:0] {
        sel_none,
        sel_spare,
        sel_debug,
        sel_link,
        sel_processor_link,
        sel_setup,
        sel_static
    } slcs_sel_t;
endpackage

// >>> src/slcs_top.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "slcs_map.svh"
module slcs_top
    import slcs_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic dbg_core_zero_evt,
    input wire logic dbg_core_one_evt,
    input wire logic [15:0] sw_source_target_kind,
    input wire logic [63:0] sw_dest_link,
    input wire logic [7:0] sw_junk,
    input wire logic [7:0] sw_dest_busy,
    input wire logic [7:0] sw_src_busy,
    input wire logic [15:0] pr_source_target_kind,
    input wire logic [63:0] pr_dest_link,
    input wire logic [7:0] pr_junk,
    input wire logic [7:0] pr_dest_busy,
    input wire logic [7:0] pr_src_busy,
    input wire logic [7:0] rx_error_evt,
    input wire logic [7:0] credit_issued_evt,
    input wire logic [7:0] credit_rx_evt,
    input wire logic [7:0] tx_sym_sent,
    input wire logic [7:0] tx_sym_last,
    output logic [7:0] tx_permit,
    output logic [7:0] link_enable,
    output logic [7:0] link_five_wire,
    output logic [31:0] link_direction,
    output logic [15:0] link_network,
    output logic [15:0] proc_link_network,
    output logic [7:0] credit_token_a_req,
    output logic [7:0] rx_reset_req,
    output logic [7:0] static_enable,
    output logic [7:0] static_proc,
    output logic [39:0] static_chanend
);
    localparam int IW = ADDR_W - 2;

    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, wdata_reg;
    logic [IW-1:0] widx_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] spare_reg, dbg_reg;
    logic dbg_rsv_reg;
    logic [31:0] dir_reg;
    logic [15:0] net_reg, pnet_reg;
    logic [7:0] en_reg, five_reg, sen_reg, proc_reg;
    logic [87:0] sgap_reg, tgap_reg;
    logic [39:0] chan_reg;
    logic [7:0] err_vec, ciss_vec, cheld_vec;
    logic wr_fire, ar_fire;
    slcs_sel_t wr_sel, ar_sel;
    logic [2:0] wn, wl;
    logic [31:0] wmask, wmerged, wset;
    logic [IW-1:0] ar_idx;

    // =====================================================
    // Address decode
    function automatic slcs_sel_t sel_of(input logic [IW-1:0] idx);
        logic [7:0] lo;
        logic hi;
        lo = idx[7:0];
        hi = |(idx >> 8);
        if (hi)
            return sel_none;
        else if (lo == `SLCS_IDX_SPARE)
            return sel_spare;
        else if (lo == `SLCS_IDX_DEBUG)
            return sel_debug;
        else if ((lo & `SLCS_GRP_MASK) == `SLCS_IDX_LINK)
            return sel_link;
        else if ((lo & `SLCS_GRP_MASK) == `SLCS_IDX_PROCESSOR_LINK)
            return sel_processor_link;
        else if ((lo & `SLCS_GRP_MASK) == `SLCS_IDX_SETUP)
            return sel_setup;
        else if ((lo & `SLCS_GRP_MASK) == `SLCS_IDX_STATIC)
            return sel_static;
        else
            return sel_none;
    endfunction

    // =====================================================
    // Read view of a register
    function automatic logic [31:0] word_at(input logic [IW-1:0] idx);
        logic [2:0] n;
        logic [2:0] l;
        logic [31:0] w;
        n = idx[2:0];
        l = n ^ `SLCS_STATIC_SWAP;
        w = `SLCS_RST_WORD;
        case (sel_of(idx))
            sel_spare: w[1:0] = spare_reg;
            sel_debug:
            begin
                w[1:0] = dbg_reg;
                w[`SLCS_DBG_RSV_BIT] = dbg_rsv_reg;
            end
            sel_link:
            begin
                w[`SLCS_KIND_LO +: 2] = sw_source_target_kind[{n, 1'b0} +: 2];
                w[`SLCS_DEST_LO +: 8] = sw_dest_link[{n, 3'b000} +: 8];
                w[`SLCS_DIR_LO +: 4] = dir_reg[{n, 2'b00} +: 4];
                w[`SLCS_NET_LO +: 2] = net_reg[{n, 1'b0} +: 2];
                w[`SLCS_JUNK_BIT] = sw_junk[n];
                w[`SLCS_DBUSY_BIT] = sw_dest_busy[n];
                w[`SLCS_SBUSY_BIT] = sw_src_busy[n];
            end
            sel_processor_link:
            begin
                w[`SLCS_KIND_LO +: 2] = pr_source_target_kind[{n, 1'b0} +: 2];
                w[`SLCS_DEST_LO +: 8] = pr_dest_link[{n, 3'b000} +: 8];
                w[`SLCS_NET_LO +: 2] = pnet_reg[{n, 1'b0} +: 2];
                w[`SLCS_JUNK_BIT] = pr_junk[n];
                w[`SLCS_DBUSY_BIT] = pr_dest_busy[n];
                w[`SLCS_SBUSY_BIT] = pr_src_busy[n];
            end
            sel_setup:
            begin
                w[`SLCS_EN_BIT] = en_reg[n];
                w[`SLCS_FIVE_BIT] = five_reg[n];
                w[`SLCS_ERR_BIT] = err_vec[n];
                w[`SLCS_CISS_BIT] = ciss_vec[n];
                w[`SLCS_CHELD_BIT] = cheld_vec[n];
                w[`SLCS_SGAP_LO +: 11] = sgap_reg[n * 11 +: 11];
                w[`SLCS_TGAP_LO +: 11] = tgap_reg[n * 11 +: 11];
            end
            sel_static:
            begin
                w[`SLCS_SEN_BIT] = sen_reg[l];
                w[`SLCS_PROC_BIT] = proc_reg[l];
                w[`SLCS_CHAN_LO +: 5] = chan_reg[l * 5 +: 5];
            end
            default: w = `SLCS_RST_WORD;
        endcase
        return w;
    endfunction

    // =====================================================
    // AXI4-Lite write channel
    assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
    assign wr_sel = sel_of(widx_reg);
    assign wn = widx_reg[2:0];
    assign wl = wn ^ `SLCS_STATIC_SWAP;

    always_comb
    begin
        wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
        wmerged = (word_at(widx_reg) & ~wmask) | (wdata_reg & wmask);
        wset = wdata_reg & wmask;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= `SLCS_RESP_OKAY;
            widx_reg <= '0;
            wdata_reg <= `SLCS_RST_WORD;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && awready_reg)
            begin
                widx_reg <= s_axi_awaddr[ADDR_W-1:2];
                awready_reg <= 1'b0;
            end
            if (s_axi_wvalid && wready_reg)
            begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                wready_reg <= 1'b0;
            end
            if (wr_fire)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= (wr_sel == sel_none) ? `SLCS_RESP_SLVERR : `SLCS_RESP_OKAY;
            end
            else if (bvalid_reg && s_axi_bready)
            begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // =====================================================
    // AXI4-Lite read channel
    assign ar_fire = s_axi_arvalid && arready_reg;
    assign ar_idx = s_axi_araddr[ADDR_W-1:2];
    assign ar_sel = sel_of(ar_idx);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= `SLCS_RST_WORD;
            rresp_reg <= `SLCS_RESP_OKAY;
        end
        else if (ar_fire)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= word_at(ar_idx);
            rresp_reg <= (ar_sel == sel_none) ? `SLCS_RESP_SLVERR : `SLCS_RESP_OKAY;
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // =====================================================
    // Debug source and spare control
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dbg_reg <= 2'h0;
            dbg_rsv_reg <= 1'b0;
            spare_reg <= 2'h0;
        end
        else
        begin
            if (dbg_core_zero_evt || dbg_core_one_evt)
                dbg_reg <= {dbg_core_one_evt, dbg_core_zero_evt};
            else if (wr_fire && wr_sel == sel_debug)
                dbg_reg <= wmerged[1:0];
            if (wr_fire && wr_sel == sel_debug)
                dbg_rsv_reg <= wmerged[`SLCS_DBG_RSV_BIT];
            if (wr_fire && wr_sel == sel_spare)
                spare_reg <= wmerged[1:0];
        end
    end

    // =====================================================
    // Direction and network assignment
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dir_reg <= 32'h0000_0000;
            net_reg <= 16'h0000;
            pnet_reg <= 16'h0000;
        end
        else if (wr_fire && wr_sel == sel_link)
        begin
            dir_reg[{wn, 2'b00} +: 4] <= wmerged[`SLCS_DIR_LO +: 4];
            net_reg[{wn, 1'b0} +: 2] <= wmerged[`SLCS_NET_LO +: 2];
        end
        else if (wr_fire && wr_sel == sel_processor_link)
        begin
            pnet_reg[{wn, 1'b0} +: 2] <= wmerged[`SLCS_NET_LO +: 2];
        end
    end

    // =====================================================
    // External link setup
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            en_reg <= 8'h00;
            five_reg <= 8'h00;
            sgap_reg <= '0;
            tgap_reg <= '0;
        end
        else if (wr_fire && wr_sel == sel_setup)
        begin
            en_reg[wn] <= wmerged[`SLCS_EN_BIT];
            five_reg[wn] <= wmerged[`SLCS_FIVE_BIT];
            sgap_reg[wn * 11 +: 11] <= wmerged[`SLCS_SGAP_LO +: 11];
            tgap_reg[wn * 11 +: 11] <= wmerged[`SLCS_TGAP_LO +: 11];
        end
    end

    // =====================================================
    // Static forwarding setup
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sen_reg <= 8'h00;
            proc_reg <= 8'h00;
            chan_reg <= '0;
        end
        else if (wr_fire && wr_sel == sel_static)
        begin
            sen_reg[wl] <= wmerged[`SLCS_SEN_BIT];
            proc_reg[wl] <= wmerged[`SLCS_PROC_BIT];
            chan_reg[wl * 5 +: 5] <= wmerged[`SLCS_CHAN_LO +: 5];
        end
    end

    // =====================================================
    // Per-link flags, pulses and transmit gap
    for (genvar i = 0; i < `SLCS_NLINK; i++)
    begin : g_link
        logic hit;
        logic err_q, ciss_q, cheld_q, credit_token_a_q, rxrst_q;
        slcs_gap_if gif ();

        assign hit = wr_fire && (wr_sel == sel_setup) && (wn == 3'(i));

        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                err_q <= 1'b0;
                ciss_q <= 1'b0;
                cheld_q <= 1'b0;
                credit_token_a_q <= 1'b0;
                rxrst_q <= 1'b0;
            end
            else
            begin
                if (rx_error_evt[i])
                    err_q <= 1'b1;
                else if (hit && wset[`SLCS_RXRST_BIT])
                    err_q <= 1'b0;
                if (credit_issued_evt[i])
                    ciss_q <= 1'b1;
                else if (hit && wset[`SLCS_RXRST_BIT])
                    ciss_q <= 1'b0;
                if (credit_rx_evt[i])
                    cheld_q <= 1'b1;
                else if (hit && wset[`SLCS_CREDIT_TOKEN_A_BIT])
                    cheld_q <= 1'b0;
                credit_token_a_q <= hit && wset[`SLCS_CREDIT_TOKEN_A_BIT];
                rxrst_q <= hit && wset[`SLCS_RXRST_BIT];
            end
        end

        assign err_vec[i] = err_q;
        assign ciss_vec[i] = ciss_q;
        assign cheld_vec[i] = cheld_q;
        assign credit_token_a_req[i] = credit_token_a_q;
        assign rx_reset_req[i] = rxrst_q;

        assign gif.sym_gap = sgap_reg[i * 11 +: 11];
        assign gif.tok_gap = tgap_reg[i * 11 +: 11];
        assign gif.sent = tx_sym_sent[i];
        assign gif.last = tx_sym_last[i];
        assign tx_permit[i] = gif.permit;

        slcs_tx_gap u_gap (
            .aclk(aclk),
            .aresetn(aresetn),
            .g(gif.gap)
        );

        err_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
            rx_error_evt[i] |=> err_vec[i] ##1
            (err_vec[i] || $past(hit && wset[`SLCS_RXRST_BIT])))
            else $error("error flag not held after event");
    end

    // =====================================================
    // Outputs
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign link_enable = en_reg;
    assign link_five_wire = five_reg;
    assign link_direction = dir_reg;
    assign link_network = net_reg;
    assign proc_link_network = pnet_reg;
    assign static_enable = sen_reg;
    assign static_proc = proc_reg;
    assign static_chanend = chan_reg;

    // =====================================================
    // Checks
    dbg_source_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (dbg_core_zero_evt && !dbg_core_one_evt) |=> (dbg_reg == 2'h1))
        else $error("debug source not core zero");

    rd_kind_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_fire && ar_sel == sel_link) |=> (rdata_reg[31:16] ==
        {6'h00, $past(sw_source_target_kind[{ar_idx[2:0], 1'b0} +: 2]),
        $past(sw_dest_link[{ar_idx[2:0], 3'b000} +: 8])}))
        else $error("link status kind or destination wrong");

    rd_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_fire && ar_sel == sel_processor_link) |=> (rdata_reg[3:0] == {1'b0,
        $past(pr_junk[ar_idx[2:0]]), $past(pr_dest_busy[ar_idx[2:0]]),
        $past(pr_src_busy[ar_idx[2:0]])}) && (rdata_reg[15:6] == 10'h000))
        else $error("processor link flags wrong");

    wr_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_sel == sel_link && wstrb_reg[1]) |=>
        (link_direction[{$past(wn), 2'b00} +: 4] == $past(wdata_reg[11:8])))
        else $error("direction not written");

    wr_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_sel == sel_setup && wstrb_reg[3]) |=>
        (link_enable[$past(wn)] == $past(wdata_reg[31])) &&
        (link_five_wire[$past(wn)] == $past(wdata_reg[30])))
        else $error("enable or wire mode not written");

    credit_token_a_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_sel == sel_setup && wset[`SLCS_CREDIT_TOKEN_A_BIT] && !credit_rx_evt[wn])
        |=> credit_token_a_req[$past(wn)] && !cheld_vec[$past(wn)]
        ##1 !credit_token_a_req[$past(wn, 2)])
        else $error("credit token request not one pulse");

    rx_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(rx_reset_req[0]) |-> $past(wr_fire && wr_sel == sel_setup && wn == 3'h0))
        else $error("receiver reset without a write");

    static_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_sel == sel_static && wstrb_reg[3]) |=>
        (static_enable[$past(wn) ^ `SLCS_STATIC_SWAP] == $past(wdata_reg[31])))
        else $error("static enable mapped to wrong link");

    resp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");

endmodule // slcs_top

// >>> src/slcs_tx_gap.sv
`timescale 1ns/1ps
module slcs_tx_gap
    import slcs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    slcs_gap_if.gap g
);
    logic [11:0] cnt_reg;
    logic permit_reg;
    logic [11:0] since_reg;
    logic [11:0] need_reg;
    logic seen_reg;

    // =====================================================
    // Idle gap counter
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_reg <= 12'h000;
            permit_reg <= 1'b1;
        end
        else if (g.sent)
        begin
            cnt_reg <= {1'b0, (g.last ? g.tok_gap : g.sym_gap)} + 12'h001;
            permit_reg <= 1'b0;
        end
        else if (cnt_reg > 12'h001)
        begin
            cnt_reg <= cnt_reg - 12'h001;
        end
        else if (cnt_reg == 12'h001)
        begin
            cnt_reg <= 12'h000;
            permit_reg <= 1'b1;
        end
    end

    assign g.permit = permit_reg;

    // =====================================================
    // Checks
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            since_reg <= 12'h000;
            need_reg <= 12'h000;
            seen_reg <= 1'b0;
        end
        else if (g.sent)
        begin
            since_reg <= 12'h000;
            need_reg <= {1'b0, (g.last ? g.tok_gap : g.sym_gap)};
            seen_reg <= 1'b1;
        end
        else if (since_reg != 12'hFFF)
        begin
            since_reg <= since_reg + 12'h001;
        end
    end

    gap_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (g.sent && seen_reg) |-> (since_reg > need_reg))
        else $error("symbol sent before idle gap elapsed");

    gap_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        g.sent |=> !g.permit)
        else $error("permit not withdrawn after send");

    gap_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!g.sent && cnt_reg == 12'h001) |=> g.permit)
        else $error("permit not restored after gap");

endmodule // slcs_tx_gap

// >>> test/slcs_far_end.sv
`timescale 1ns/1ps
// =====================================================
// Far end: link status levels, prompt symbol sender
module slcs_far_end
(
    input wire logic aclk,
    input wire logic run,
    input wire logic [7:0] permit,
    output logic [7:0] sent,
    output logic [7:0] last,
    output logic [15:0] kind,
    output logic [63:0] dest,
    output logic [23:0] flg,
    output int min_sym,
    output int min_tok
);
    int idle = 999;
    logic tl = 1'b0;
    logic pl = 1'b0;
    assign kind = 16'h0008;
    assign dest = 64'h5A00;
    assign flg = 24'h020200;
    assign sent = {7'h00, run & permit[0]};
    assign last = {7'h00, tl};
    always @(posedge aclk)
    begin
        if (!run)
        begin
            idle <= 999;
            min_sym <= 999;
            min_tok <= 999;
        end
        else if (sent[0])
        begin
            if (idle < 900 && !pl && idle < min_sym)
                min_sym <= idle;
            if (idle < 900 && pl && idle < min_tok)
                min_tok <= idle;
            pl <= tl;
            tl <= ~tl;
            idle <= 0;
        end
        else
            idle <= idle + 1;
    end
endmodule // slcs_far_end

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0, rdata;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, run = 1'b0;
    logic [4:0] ev = 5'h00;
    logic [3:0] ws = 4'hF;
    logic awr, wrr, bv, arr, rv;
    logic [1:0] bresp, rresp;
    logic [7:0] tx_permit, link_enable, link_five_wire, credit_token_a_req, rx_reset_req;
    logic [7:0] static_enable, static_proc, sent, last;
    logic [31:0] link_direction;
    logic [15:0] link_network, proc_link_network, kind, req;
    logic [63:0] dest;
    logic [39:0] static_chanend;
    logic [23:0] flg;
    int min_sym, min_tok;
    int fails = 0;
    int checked = 0;
    always #20 aclk = ~aclk;
    slcs_far_end far (.aclk, .run, .permit(tx_permit), .sent, .last, .kind, .dest, .flg,
        .min_sym, .min_tok);
    slcs_top #(.ADDR_W(12)) dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .dbg_core_zero_evt(ev[0]), .dbg_core_one_evt(ev[1]), .sw_source_target_kind(kind),
        .sw_dest_link(dest), .sw_junk(flg[23:16]), .sw_dest_busy(flg[15:8]),
        .sw_src_busy(flg[7:0]), .pr_source_target_kind(~kind), .pr_dest_link(~dest),
        .pr_junk(~flg[23:16]), .pr_dest_busy(~flg[15:8]), .pr_src_busy(~flg[7:0]),
        .rx_error_evt({7'h00, ev[2]}), .credit_issued_evt({7'h00, ev[3]}),
        .credit_rx_evt({7'h00, ev[4]}), .tx_sym_sent(sent), .tx_sym_last(last), .tx_permit,
        .link_enable, .link_five_wire, .link_direction, .link_network, .proc_link_network,
        .credit_token_a_req, .rx_reset_req, .static_enable, .static_proc, .static_chanend);
    // =====================================================
    // Bus, event and report tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [1:0] er = 2'h0);
        awa <= {i, 2'h0};
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!awr);
                awv <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!wrr);
                wv <= 1'b0;
            end
        join
        do @(posedge aclk); while (!bv);
        req = {rx_reset_req, credit_token_a_req};
        br <= 1'b1;
        do @(posedge aclk); while (!bv);
        br <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
    endtask
    task automatic rc(input logic [9:0] i, input logic [31:0] e, input logic [1:0] er = 2'h0);
        ara <= {i, 2'h0};
        arv <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        rr <= 1'b1;
        do @(posedge aclk); while (!rv);
        rr <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
    endtask
    task automatic pulse(input logic [4:0] m);
        ev <= m;
        @(posedge aclk);
        ev <= 5'h00;
        @(posedge aclk);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // =====================================================
    // Tests
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(10'h080, 32'h0);
        rc(10'h0A0, 32'h0);
        $display("test reset done");
        wr(10'h021, 32'hFFFF_FFFF);
        rc(10'h021, 32'h025A_0F36);
        chk("lnk", 32'h3F, 32'({link_network[3:2], link_direction[7:4]}));
        ws <= 4'h1;
        wr(10'h021, 32'h0);
        ws <= 4'hF;
        rc(10'h021, 32'h025A_0F06);
        wr(10'h041, 32'hFFFF_FFFF);
        rc(10'h041, 32'h01A5_0031);
        chk("pnet", 32'h3, 32'(proc_link_network[3:2]));
        $display("test status done");
        pulse(5'h02);
        rc(10'h01F, 32'h2);
        pulse(5'h01);
        rc(10'h01F, 32'h1);
        pulse(5'h1C);
        rc(10'h080, 32'h0E00_0000);
        wr(10'h080, 32'h0100_0000);
        chk("req", 32'h1, 32'(req));
        rc(10'h080, 32'h0C00_0000);
        wr(10'h080, 32'h0080_0000);
        chk("req", 32'h100, 32'(req));
        rc(10'h080, 32'h0);
        $display("test flags done");
        wr(10'h080, 32'hC000_1003);
        rc(10'h080, 32'hC000_1003);
        chk("mode", 32'h3, 32'({link_enable[0], link_five_wire[0]}));
        run <= 1'b1;
        repeat (60) @(posedge aclk);
        run <= 1'b0;
        chk("sym gap", 32'd3, min_sym);
        chk("tok gap", 32'd4, min_tok);
        $display("test gap done");
        for (int i = 0; i < 8; i++)
        begin
            wr(10'h0A0 + 10'(i), 32'h8000_0100 | 32'(i));
            chk("static", 32'h60 | 32'(i), 32'({static_enable[i ^ 2], static_proc[i ^ 2],
                static_chanend[5 * (i ^ 2) +: 5]}));
        end
        wr(10'h0A7, 32'hFFFF_FFFF);
        rc(10'h0A7, 32'h8000_011F);
        rc(10'h030, 32'h0, 2'h2);
        wr(10'h030, 32'h1, 2'h2);
        wr(10'h011, 32'hFFFF_FFFF);
        rc(10'h011, 32'h3);
        wr(10'h01F, 32'hFFFF_FFFF);
        rc(10'h01F, 32'h13);
        $display("test static done");
        final_report;
    end
    initial
    begin
        repeat (5000) @(posedge aclk);
        fails++;
        final_report;
    end
endmodule // testbench
